//--- core/msgobj_consts.vh
// Purpose: constants of the message-object controller
// Assumes: included by the controller, its checker and its bench
// Notes:   offsets are byte addresses on a 32-bit APB
`ifndef MSGOBJ_CONSTS_VH
`define MSGOBJ_CONSTS_VH

`define OBJ_COUNT      32
`define OBJ_IDX_W      5
// ****************************************
// register offsets
// ****************************************
`define OFF_STATUS     8'h00
`define OFF_PEND_MAP   8'h04
`define OFF_FRESH_MAP  8'h08
`define OFF_VALID_MAP  8'h0c
`define OFF_CONTROL    8'h10
`define OFF_CAUSE      8'h14
`define OFF_COMMAND    8'h18
`define OFF_STG_CFG    8'h1c
`define OFF_STG_ID     8'h20
`define OFF_STG_MASK   8'h24
`define OFF_STG_DLO    8'h28
`define OFF_STG_DHI    8'h2c
// ****************************************
// control and command fields
// ****************************************
`define CTL_RESEND     0
`define CTL_GIE        1
`define CMD_NUM_HI     5
`define CMD_COMMIT     8
`define CMD_CLEAR      9
`define CMD_READ       10
`define CMD_SEND       11
`define NUM_FIRST      6'h01
`define NUM_LAST       6'h20
// ****************************************
// staging configuration fields
// ****************************************
`define CFG_KIND_HI    2
`define CFG_TXIE       4
`define CFG_RXIE       5
`define CFG_FILT       6
`define CFG_EXT        7
`define CFG_LEN_LO     8
`define CFG_LEN_HI     11
`define CFG_FRESH      12
`define CFG_LOST       13
// ****************************************
// object kinds
// ****************************************
`define KIND_SEND      3'h0
`define KIND_SEND_REQ  3'h1
`define KIND_RECV      3'h2
`define KIND_RECV_REQ  3'h3
`define KIND_AUTO_ANS  3'h4
// ****************************************
// status register fields and codes
// ****************************************
`define ST_LEC_HI      2
`define ST_TXOK        3
`define ST_RXOK        4
`define ST_EPASS       5
`define ST_EWARN       6
`define ST_BOFF        7
`define LEC_NONE       3'h0
`define LEC_STUFF      3'h1
`define LEC_FORM       3'h2
`define LEC_ACK        3'h3
`define LEC_BIT1       3'h4
`define LEC_BIT0       3'h5
`define LEC_CRC        3'h6
`define WARN_LEVEL     8'h60
`define CAUSE_STATUS   32'h0000_8000
`define STD_ID_MASK    29'h0000_07ff
`define EXT_ID_MASK    29'h1fff_ffff

`endif

//--- core/msgobj_ctrl.v
// Purpose: message-object controller for a CAN node, APB register side
// Assumes: frame engine on CORE_CLK delivers whole frames and error events
// Notes:   object state lives in flip-flops; lowest object number wins
`timescale 1ns/100ps
`include "msgobj_consts.vh"

module msgobj_ctrl (
    input  wire        CORE_CLK,
    input  wire        SRST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    output wire        IRQ,
    input  wire        RX_VALID,
    input  wire [28:0] RX_ID,
    input  wire        RX_EXT,
    input  wire        RX_RTR,
    input  wire [3:0]  RX_LEN,
    input  wire [63:0] RX_DATA,
    output wire        TX_VALID,
    output wire [28:0] TX_ID,
    output wire        TX_EXT,
    output wire        TX_RTR,
    output wire [3:0]  TX_LEN,
    output wire [63:0] TX_DATA,
    input  wire        TX_DONE,
    input  wire        TX_FAIL,
    input  wire        ERR_EVENT,
    input  wire [2:0]  ERR_CODE,
    input  wire [7:0]  TX_ERR_COUNT,
    input  wire [7:0]  RX_ERR_COUNT,
    input  wire        BUS_OFF,
    input  wire        ERR_PASSIVE
);

// ****************************************
// storage
// ****************************************
// object store
reg  [2:0]                  kind_reg [0:`OBJ_COUNT-1];
reg  [28:0]                 id_reg   [0:`OBJ_COUNT-1];
reg  [28:0]                 mask_reg [0:`OBJ_COUNT-1];
reg  [3:0]                  flag_reg [0:`OBJ_COUNT-1];
reg  [3:0]                  len_reg  [0:`OBJ_COUNT-1];
reg  [63:0]                 data_reg [0:`OBJ_COUNT-1];
reg  [`OBJ_COUNT-1:0]       valid_reg;
reg  [`OBJ_COUNT-1:0]       pend_reg;
reg  [`OBJ_COUNT-1:0]       fresh_reg;
reg  [`OBJ_COUNT-1:0]       lost_reg;
reg  [`OBJ_COUNT-1:0]       oirq_reg;
reg  [1:0]                  ctrl_reg;
reg  [13:0]                 stg_cfg_reg;
reg  [28:0]                 stg_id_reg;
reg  [28:0]                 stg_mask_reg;
reg  [63:0]                 stg_data_reg;
reg  [2:0]                  lec_reg;
reg                         txok_reg;
reg                         rxok_reg;
reg                         ewarn_reg;
reg                         epass_reg;
reg                         boff_reg;
reg                         sirq_reg;
reg                         irq_reg;
reg                         pready_reg;
reg                         pslverr_reg;
reg  [31:0]                 prdata_reg;
reg                         tx_busy_reg;
reg  [`OBJ_IDX_W-1:0]       tx_idx_reg;
reg                         tx_valid_reg;
reg  [28:0]                 tx_id_reg;
reg                         tx_ext_reg;
reg                         tx_rtr_reg;
reg  [3:0]                  tx_len_reg;
reg  [63:0]                 tx_data_reg;

integer                     i;
integer                     j;

// ****************************************
// bus decode
// ****************************************
wire                        access   = PSEL & PENABLE & ~pready_reg;
wire                        wr_fire  = PSEL & PENABLE & pready_reg & PWRITE;
wire                        rd_fire  = PSEL & PENABLE & pready_reg & ~PWRITE;
wire [5:0]                  cmd_num  = PWDATA[`CMD_NUM_HI:0];
wire [5:0]                  cmd_off  = cmd_num - `NUM_FIRST;
wire [`OBJ_IDX_W-1:0]       cmd_idx  = cmd_off[`OBJ_IDX_W-1:0];
wire                        cmd_ok   = (cmd_num >= `NUM_FIRST) && (cmd_num <= `NUM_LAST);
wire                        cmd_wr   = wr_fire && (PADDR == `OFF_COMMAND) && cmd_ok;
wire [2:0]                  stg_kind = stg_cfg_reg[`CFG_KIND_HI:0];

// ****************************************
// receive match and transmit pick
// ****************************************
reg                         rx_hit;
reg  [`OBJ_IDX_W-1:0]       rx_idx;
reg                         kind_ok;
reg  [28:0]                 cmp_mask;
reg                         tx_any;
reg  [`OBJ_IDX_W-1:0]       tx_pick;
reg                         oirq_any;
reg  [31:0]                 cause;

always @* begin
    rx_hit   = 1'b0;
    rx_idx   = {`OBJ_IDX_W{1'b0}};
    kind_ok  = 1'b0;
    cmp_mask = `EXT_ID_MASK;
    tx_any   = 1'b0;
    tx_pick  = {`OBJ_IDX_W{1'b0}};
    oirq_any = 1'b0;
    cause    = 32'h0000_0000;
    // descending scan so the lowest number is left standing
    for (i = `OBJ_COUNT - 1; i >= 0; i = i - 1) begin
        // data frames go to receivers, remote frames to responders
        if (RX_RTR)
            kind_ok = (kind_reg[i] == `KIND_RECV_REQ) || (kind_reg[i] == `KIND_AUTO_ANS);
        else
            kind_ok = (kind_reg[i] == `KIND_RECV) || (kind_reg[i] == `KIND_SEND_REQ);
        // standard ids compare eleven bits only
        cmp_mask = flag_reg[i][3] ? `EXT_ID_MASK : `STD_ID_MASK;
        // mask applies only with the filter flag
        if (flag_reg[i][2])
            cmp_mask = cmp_mask & mask_reg[i];
        if (valid_reg[i] && kind_ok && (flag_reg[i][3] == RX_EXT) &&
            (((id_reg[i] ^ RX_ID) & cmp_mask) == 29'h0000_0000)) begin
            rx_hit = 1'b1;
            rx_idx = i[`OBJ_IDX_W-1:0];
        end
        if (pend_reg[i]) begin
            tx_any  = 1'b1;
            tx_pick = i[`OBJ_IDX_W-1:0];
        end
        // lowest pending object reported as its number
        if (oirq_reg[i]) begin
            oirq_any = 1'b1;
            cause    = i + 1;
        end
    end
    if (sirq_reg)
        cause = `CAUSE_STATUS;
end

// ****************************************
// read mux
// ****************************************
reg  [31:0]                 rd_mux;
reg                         rd_hit;

always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
        `OFF_STATUS:    rd_mux = {24'h00_0000, boff_reg, ewarn_reg, epass_reg, rxok_reg, txok_reg, lec_reg};
        `OFF_PEND_MAP:  rd_mux = pend_reg;
        `OFF_FRESH_MAP: rd_mux = fresh_reg;
        `OFF_VALID_MAP: rd_mux = valid_reg;
        `OFF_CONTROL:   rd_mux = {30'h0000_0000, ctrl_reg};
        `OFF_CAUSE:     rd_mux = cause;
        `OFF_COMMAND:   rd_mux = 32'h0000_0000;
        `OFF_STG_CFG:   rd_mux = {18'h0_0000, stg_cfg_reg};
        `OFF_STG_ID:    rd_mux = {3'h0, stg_id_reg};
        `OFF_STG_MASK:  rd_mux = {3'h0, stg_mask_reg};
        `OFF_STG_DLO:   rd_mux = stg_data_reg[31:0];
        `OFF_STG_DHI:   rd_mux = stg_data_reg[63:32];
        default:        rd_hit = 1'b0;
    endcase
end

// ****************************************
// apb slave: one wait state on every access
// ****************************************
always @(posedge CORE_CLK) begin
    if (SRST) begin
        pready_reg  <= 1'b0;
        pslverr_reg <= 1'b0;
        prdata_reg  <= 32'h0000_0000;
    end else begin
        pready_reg  <= access;
        pslverr_reg <= access & ~rd_hit;
        if (access && !PWRITE)
            prdata_reg <= rd_mux;
    end
end

// ****************************************
// control, staging and status
// ****************************************
always @(posedge CORE_CLK) begin
    if (SRST) begin
        ctrl_reg     <= 2'h0;
        stg_cfg_reg  <= 14'h0000;
        stg_id_reg   <= 29'h0000_0000;
        stg_mask_reg <= 29'h0000_0000;
        stg_data_reg <= 64'h0000_0000_0000_0000;
        lec_reg      <= `LEC_NONE;
        txok_reg     <= 1'b0;
        rxok_reg     <= 1'b0;
        ewarn_reg    <= 1'b0;
        epass_reg    <= 1'b0;
        boff_reg     <= 1'b0;
        sirq_reg     <= 1'b0;
        irq_reg      <= 1'b0;
    end else begin
        if (wr_fire) begin
            case (PADDR)
                `OFF_CONTROL:  ctrl_reg     <= PWDATA[1:0];
                `OFF_STG_CFG:  stg_cfg_reg  <= PWDATA[13:0];
                `OFF_STG_ID:   stg_id_reg   <= PWDATA[28:0];
                `OFF_STG_MASK: stg_mask_reg <= PWDATA[28:0];
                `OFF_STG_DLO:  stg_data_reg[31:0]  <= PWDATA;
                `OFF_STG_DHI:  stg_data_reg[63:32] <= PWDATA;
                default: ;
            endcase
        end
        if (cmd_wr && PWDATA[`CMD_READ]) begin
            stg_cfg_reg  <= {lost_reg[cmd_idx], fresh_reg[cmd_idx], len_reg[cmd_idx],
                             flag_reg[cmd_idx], 1'b0, kind_reg[cmd_idx]};
            stg_id_reg   <= id_reg[cmd_idx];
            stg_mask_reg <= mask_reg[cmd_idx];
            stg_data_reg <= data_reg[cmd_idx];
        end
        boff_reg  <= BUS_OFF;
        epass_reg <= ERR_PASSIVE;
        ewarn_reg <= (TX_ERR_COUNT >= `WARN_LEVEL) || (RX_ERR_COUNT >= `WARN_LEVEL);
        // status read clears; later sets below still win
        if (rd_fire && (PADDR == `OFF_STATUS)) begin
            sirq_reg <= 1'b0;
            txok_reg <= 1'b0;
            rxok_reg <= 1'b0;
        end
        // last error code as delivered by the engine
        if (ERR_EVENT) begin
            lec_reg  <= ERR_CODE;
            sirq_reg <= 1'b1;
        end
        if (BUS_OFF != boff_reg)
            sirq_reg <= 1'b1;
        // any good frame, matched or not
        if (RX_VALID) begin
            rxok_reg <= 1'b1;
            sirq_reg <= 1'b1;
        end
        if (tx_busy_reg && TX_DONE) begin
            txok_reg <= 1'b1;
            sirq_reg <= 1'b1;
        end
        irq_reg <= ctrl_reg[`CTL_GIE] & (sirq_reg | oirq_any);
    end
end

// ****************************************
// object state and transmit sequencing
// ****************************************
always @(posedge CORE_CLK) begin
    if (SRST) begin
        valid_reg    <= {`OBJ_COUNT{1'b0}};
        pend_reg     <= {`OBJ_COUNT{1'b0}};
        fresh_reg    <= {`OBJ_COUNT{1'b0}};
        lost_reg     <= {`OBJ_COUNT{1'b0}};
        oirq_reg     <= {`OBJ_COUNT{1'b0}};
        tx_busy_reg  <= 1'b0;
        tx_idx_reg   <= {`OBJ_IDX_W{1'b0}};
        tx_valid_reg <= 1'b0;
        tx_id_reg    <= 29'h0000_0000;
        tx_ext_reg   <= 1'b0;
        tx_rtr_reg   <= 1'b0;
        tx_len_reg   <= 4'h0;
        tx_data_reg  <= 64'h0000_0000_0000_0000;
        for (j = 0; j < `OBJ_COUNT; j = j + 1) begin
            kind_reg[j] <= `KIND_SEND;
            id_reg[j]   <= 29'h0000_0000;
            mask_reg[j] <= 29'h0000_0000;
            flag_reg[j] <= 4'h0;
            len_reg[j]  <= 4'h0;
            data_reg[j] <= 64'h0000_0000_0000_0000;
        end
    end else begin
        if (cmd_wr) begin
            // commit overwrites every field and flag
            if (PWDATA[`CMD_COMMIT]) begin
                kind_reg[cmd_idx]  <= stg_kind;
                id_reg[cmd_idx]    <= stg_id_reg;
                mask_reg[cmd_idx]  <= stg_mask_reg;
                flag_reg[cmd_idx]  <= stg_cfg_reg[`CFG_EXT:`CFG_TXIE];
                len_reg[cmd_idx]   <= stg_cfg_reg[`CFG_LEN_HI:`CFG_LEN_LO];
                data_reg[cmd_idx]  <= stg_data_reg;
                valid_reg[cmd_idx] <= 1'b1;
                pend_reg[cmd_idx]  <= (stg_kind == `KIND_SEND) || (stg_kind == `KIND_SEND_REQ);
                fresh_reg[cmd_idx] <= 1'b0;
                lost_reg[cmd_idx]  <= 1'b0;
                oirq_reg[cmd_idx]  <= 1'b0;
            end
            if (PWDATA[`CMD_SEND] && valid_reg[cmd_idx])
                pend_reg[cmd_idx] <= 1'b1;
            if (PWDATA[`CMD_READ]) begin
                fresh_reg[cmd_idx] <= 1'b0;
                lost_reg[cmd_idx]  <= 1'b0;
                oirq_reg[cmd_idx]  <= 1'b0;
            end
            // cleared objects drop out of every map
            if (PWDATA[`CMD_CLEAR]) begin
                valid_reg[cmd_idx] <= 1'b0;
                pend_reg[cmd_idx]  <= 1'b0;
                fresh_reg[cmd_idx] <= 1'b0;
                lost_reg[cmd_idx]  <= 1'b0;
                oirq_reg[cmd_idx]  <= 1'b0;
            end
        end
        // frame arrival beats a same-cycle read of that object
        if (RX_VALID && rx_hit) begin
            if (kind_reg[rx_idx] == `KIND_AUTO_ANS) begin
                // remote frame triggers the stored answer
                pend_reg[rx_idx] <= 1'b1;
            end else begin
                // payload and length taken from the frame
                if (!RX_RTR) begin
                    data_reg[rx_idx] <= RX_DATA;
                    len_reg[rx_idx]  <= RX_LEN;
                end
                fresh_reg[rx_idx] <= 1'b1;
                if (fresh_reg[rx_idx])
                    lost_reg[rx_idx] <= 1'b1;
                if (flag_reg[rx_idx][1])
                    oirq_reg[rx_idx] <= 1'b1;
            end
        end
        if (!tx_busy_reg) begin
            if (tx_any) begin
                tx_busy_reg  <= 1'b1;
                tx_idx_reg   <= tx_pick;
                tx_valid_reg <= 1'b1;
                tx_id_reg    <= id_reg[tx_pick];
                tx_ext_reg   <= flag_reg[tx_pick][3];
                tx_rtr_reg   <= (kind_reg[tx_pick] == `KIND_SEND_REQ);
                tx_len_reg   <= len_reg[tx_pick];
                tx_data_reg  <= data_reg[tx_pick];
            end
        end else if (TX_DONE) begin
            tx_busy_reg  <= 1'b0;
            tx_valid_reg <= 1'b0;
            pend_reg[tx_idx_reg] <= 1'b0;
            if (flag_reg[tx_idx_reg][0])
                oirq_reg[tx_idx_reg] <= 1'b1;
        end else if (TX_FAIL) begin
            tx_busy_reg  <= 1'b0;
            tx_valid_reg <= 1'b0;
            // without resend the request is dropped
            if (!ctrl_reg[`CTL_RESEND])
                pend_reg[tx_idx_reg] <= 1'b0;
        end
    end
end

// ****************************************
// outputs
// ****************************************
// maps are read-only views in the read mux
assign PRDATA   = prdata_reg;
assign PREADY   = pready_reg;
assign PSLVERR  = pslverr_reg;
assign IRQ      = irq_reg;
assign TX_VALID = tx_valid_reg;
assign TX_ID    = tx_id_reg;
assign TX_EXT   = tx_ext_reg;
assign TX_RTR   = tx_rtr_reg;
assign TX_LEN   = tx_len_reg;
assign TX_DATA  = tx_data_reg;

endmodule // msgobj_ctrl

//--- testbench/msgobj_chk.sv
// Purpose: port-level checks of the message-object controller
// Assumes: bound into msgobj_ctrl, one clock domain
// Notes:   control bits are shadowed from completed APB writes
`timescale 1ns/100ps
`include "msgobj_consts.vh"

module msgobj_chk (
    input wire        CORE_CLK,
    input wire        SRST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PWDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        IRQ,
    input wire        RX_VALID,
    input wire        TX_VALID,
    input wire        TX_DONE,
    input wire        TX_FAIL
);
    // ****************************************
    // control shadow and properties
    // ****************************************
    reg  [1:0] ctl_reg;
    wire       done = PSEL && PENABLE && PREADY;

    always @(posedge CORE_CLK) begin
        if (SRST)
            ctl_reg <= 2'h0;
        else if (done && PWRITE && PADDR == `OFF_CONTROL)
            ctl_reg <= PWDATA[1:0];
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    sequence s_access; PSEL && $rose(PENABLE); endsequence
    sequence s_reoffer; !TX_VALID ##1 TX_VALID; endsequence

    property p_wait_state; s_access |-> !PREADY ##1 PREADY; endproperty
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    property p_err_unmapped; done && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > `OFF_STG_DHI); endproperty
    property p_err_with_ready; PSLVERR |-> PREADY; endproperty
    property p_tx_hold; TX_VALID && !TX_DONE && !TX_FAIL |=> TX_VALID; endproperty
    property p_tx_drop; TX_VALID && TX_DONE |=> !TX_VALID; endproperty
    property p_resend; TX_VALID && TX_FAIL && ctl_reg[0] |=> s_reoffer; endproperty
    // irq register may lag the enable by one cycle
    property p_irq_gate; !ctl_reg[1] && $past(ctl_reg) == 2'h0 |-> !IRQ; endproperty
    property p_rx_irq; RX_VALID && ctl_reg[1] |-> ##[1:2] IRQ; endproperty

    a_wait_state: assert property (p_wait_state) else $error("access not one wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    a_err_unmapped: assert property (p_err_unmapped) else $error("slave error wrong");
    a_err_with_ready: assert property (p_err_with_ready) else $error("slave error without ready");
    a_tx_hold: assert property (p_tx_hold) else $error("offer withdrawn early");
    a_tx_drop: assert property (p_tx_drop) else $error("offer kept after send");
    a_resend: assert property (p_resend) else $error("failed frame not offered again");
    a_irq_gate: assert property (p_irq_gate) else $error("irq while globally disabled");
    a_rx_irq: assert property (p_rx_irq) else $error("no irq after good frame");
endmodule // msgobj_chk

bind msgobj_ctrl msgobj_chk i_chk (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .PSLVERR, .IRQ, .RX_VALID, .TX_VALID, .TX_DONE, .TX_FAIL);

//--- testbench/can_engine_model.sv
// Purpose: frame engine stand-in on the bus side of the controller
// Assumes: same clock as the controller
// Notes:   answers after wait_cyc cycles; the first fails offers fail
`timescale 1ns/100ps

module can_engine_model (
    input  wire        CORE_CLK,
    input  wire        TX_VALID,
    output reg         TX_DONE,
    output reg         TX_FAIL,
    output reg         RX_VALID,
    output reg  [28:0] RX_ID,
    output reg         RX_EXT,
    output reg         RX_RTR,
    output reg  [3:0]  RX_LEN,
    output reg  [63:0] RX_DATA,
    output reg         ERR_EVENT,
    output reg  [2:0]  ERR_CODE
);
    // ****************************************
    // transmit answer and receive stimulus
    // ****************************************
    int wait_cyc = 0;
    int fails    = 0;
    int offers   = 0;
    int cnt      = 0;
    reg tx_q     = 1'b0;

    initial begin
        {TX_DONE, TX_FAIL, RX_VALID, ERR_EVENT} = 4'h0;
        {RX_ID, RX_EXT, RX_RTR, RX_LEN, RX_DATA, ERR_CODE} = '1;
    end

    always @(posedge CORE_CLK) begin
        tx_q <= TX_VALID;
        TX_DONE <= 1'b0;
        TX_FAIL <= 1'b0;
        if (TX_VALID && !tx_q)
            offers <= offers + 1;
        if (TX_VALID && !TX_DONE && !TX_FAIL) begin
            cnt <= cnt + 1;
            if (cnt >= wait_cyc) begin
                cnt <= 0;
                fails <= (fails > 0) ? fails - 1 : 0;
                if (fails > 0)
                    TX_FAIL <= 1'b1;
                else
                    TX_DONE <= 1'b1;
            end
        end
    end

    // released lines show the inverse, never the last frame
    task automatic rx(input [28:0] id, input ext, input rtr, input [63:0] d);
        @(posedge CORE_CLK);
        {RX_VALID, RX_ID, RX_EXT, RX_RTR, RX_LEN, RX_DATA} <= {1'b1, id, ext, rtr, 4'h8, d};
        @(posedge CORE_CLK);
        {RX_VALID, RX_ID, RX_EXT, RX_RTR, RX_LEN, RX_DATA} <= {1'b0, ~id, ~ext, ~rtr, 4'h7, ~d};
    endtask

    task automatic err(input [2:0] c);
        @(posedge CORE_CLK);
        {ERR_EVENT, ERR_CODE} <= {1'b1, c};
        @(posedge CORE_CLK);
        {ERR_EVENT, ERR_CODE} <= {1'b0, ~c};
    endtask
endmodule // can_engine_model

//--- testbench/tb.sv
// Purpose: register-level test of the message-object controller
// Assumes: APB answers within a bounded wait
// Notes:   objects configured through staging registers and commands
`timescale 1ns/100ps
`include "msgobj_consts.vh"

module tb;
    // ****************************************
    // signals, instances and tasks
    // ****************************************
    reg         CORE_CLK = 1'b0;
    reg         SRST = 1'b1;
    reg         PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    reg  [7:0]  PADDR = 8'h00, TX_ERR_COUNT = 8'h00, RX_ERR_COUNT = 8'h00;
    reg  [31:0] PWDATA = 32'h0, rdata;
    reg         BUS_OFF = 1'b0, ERR_PASSIVE = 1'b0, slverr;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, IRQ, RX_VALID, RX_EXT, RX_RTR, TX_VALID, TX_EXT, TX_RTR, TX_DONE, TX_FAIL, ERR_EVENT;
    wire [28:0] RX_ID, TX_ID;
    wire [3:0]  RX_LEN, TX_LEN;
    wire [63:0] RX_DATA, TX_DATA;
    wire [2:0]  ERR_CODE;
    integer     errors = 0, checks = 0, n0;

    msgobj_ctrl i_dut (.CORE_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .IRQ, .RX_VALID, .RX_ID, .RX_EXT, .RX_RTR, .RX_LEN, .RX_DATA, .TX_VALID, .TX_ID, .TX_EXT, .TX_RTR, .TX_LEN,
        .TX_DATA, .TX_DONE, .TX_FAIL, .ERR_EVENT, .ERR_CODE, .TX_ERR_COUNT, .RX_ERR_COUNT, .BUS_OFF, .ERR_PASSIVE);
    can_engine_model i_eng (.CORE_CLK, .TX_VALID, .TX_DONE, .TX_FAIL, .RX_VALID, .RX_ID, .RX_EXT, .RX_RTR,
        .RX_LEN, .RX_DATA, .ERR_EVENT, .ERR_CODE);

    initial forever #50 CORE_CLK = ~CORE_CLK;

    task automatic chk(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        @(posedge CORE_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n = n + 1;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rdata = PRDATA;
        slverr = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
    endtask

    task automatic wr(input [7:0] a, input [31:0] d); apb(1'b1, a, d); endtask
    task automatic rc(input [7:0] a, input [31:0] e); apb(1'b0, a, 32'h0); chk(rdata, e); endtask
    task automatic cmd(input integer b, input [5:0] n); wr(`OFF_COMMAND, (32'h1 << b) | {26'h0, n}); endtask

    task automatic cfg(input [5:0] n, input [31:0] c, input [28:0] id, input [28:0] m, input [63:0] d);
        wr(`OFF_STG_CFG, c);
        wr(`OFF_STG_ID, {3'h0, id});
        wr(`OFF_STG_MASK, {3'h0, m});
        wr(`OFF_STG_DLO, d[31:0]);
        wr(`OFF_STG_DHI, d[63:32]);
        cmd(`CMD_COMMIT, n);
    endtask

    task automatic wait_tx(input v);
        integer n;
        n = 0;
        while (TX_VALID !== v && n < 200) begin
            @(posedge CORE_CLK);
            n = n + 1;
        end
        if (n >= 200) chk(32'h0, 32'h1);
    endtask

    task automatic test_done;
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        errors = errors + 1;
        test_done;
    end

    initial begin
        repeat (12) @(posedge CORE_CLK);
        SRST <= 1'b0;
        for (int a = 0; a < 24; a += 4) rc(a[7:0], 32'h0);
        rc(8'h40, 32'h0);
        chk({31'h0, slverr}, 32'h1);
        i_eng.rx(29'h0, 1'b0, 1'b0, 64'h0);
        rc(`OFF_STATUS, 32'h10);
        chk({31'h0, IRQ}, 32'h0);
        wr(`OFF_CONTROL, 32'h3);
        rc(`OFF_CONTROL, 32'h3);
        // extended send object with transmit irq
        i_eng.wait_cyc = 30;
        cfg(6'd3, 32'h0890, 29'h1abc_def1, 29'h0, 64'h8877_6655_4433_2211);
        rc(`OFF_PEND_MAP, 32'h4);
        rc(`OFF_VALID_MAP, 32'h4);
        wait_tx(1'b1);
        chk({2'b0, TX_EXT, TX_ID}, {3'b001, 29'h1abc_def1});
        chk({27'h0, TX_RTR, TX_LEN}, 32'h8);
        chk(TX_DATA[63:32], 32'h8877_6655);
        wait_tx(1'b0);
        rc(`OFF_PEND_MAP, 32'h0);
        rc(`OFF_CAUSE, `CAUSE_STATUS);
        rc(`OFF_STATUS, 32'h08);
        rc(`OFF_CAUSE, 32'h3);
        rc(`OFF_STATUS, 32'h0);
        chk({31'h0, IRQ}, 32'h1);
        cmd(`CMD_READ, 6'd3);
        rc(`OFF_CAUSE, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        // two failures, then resend switched off
        i_eng.wait_cyc = 0;
        i_eng.fails = 2;
        n0 = i_eng.offers;
        cfg(6'd1, 32'h0800, 29'h0123, 29'h0, 64'h0);
        repeat (3) begin
            wait_tx(1'b1);
            wait_tx(1'b0);
        end
        chk(i_eng.offers - n0, 32'h3);
        wr(`OFF_CONTROL, 32'h2);
        i_eng.fails = 1;
        n0 = i_eng.offers;
        cmd(`CMD_SEND, 6'd1);
        wait_tx(1'b1);
        wait_tx(1'b0);
        rc(`OFF_STATUS, 32'h08);
        chk(i_eng.offers - n0, 32'h1);
        // masked receive, overwrite before readout
        cfg(6'd5, 32'h0862, 29'h01a0, 29'h07f0, 64'h0);
        i_eng.rx(29'h02a5, 1'b0, 1'b0, 64'h1);
        rc(`OFF_FRESH_MAP, 32'h0);
        rc(`OFF_STATUS, 32'h10);
        i_eng.rx(29'h01a5, 1'b0, 1'b0, 64'h11);
        i_eng.rx(29'h01ab, 1'b0, 1'b0, 64'h22);
        rc(`OFF_FRESH_MAP, 32'h10);
        rc(`OFF_STATUS, 32'h10);
        rc(`OFF_CAUSE, 32'h5);
        cmd(`CMD_READ, 6'd5);
        rc(`OFF_STG_CFG, 32'h3862);
        rc(`OFF_STG_DLO, 32'h22);
        rc(`OFF_FRESH_MAP, 32'h0);
        // error levels and every error code
        {BUS_OFF, ERR_PASSIVE, TX_ERR_COUNT} <= {2'b11, 8'h60};
        rc(`OFF_STATUS, 32'he0);
        {BUS_OFF, ERR_PASSIVE, TX_ERR_COUNT, RX_ERR_COUNT} <= {2'b00, 8'h5f, 8'h60};
        rc(`OFF_STATUS, 32'h40);
        RX_ERR_COUNT <= 8'h5f;
        rc(`OFF_STATUS, 32'h0);
        for (int c = 1; c < 8; c++) begin
            i_eng.err(3'(c % 7));
            rc(`OFF_STATUS, c % 7);
        end
        // remaining kinds, remote lengths kept non-zero
        cfg(6'd2, 32'h0801, 29'h0077, 29'h0, 64'h0);
        wait_tx(1'b1);
        chk({2'b0, TX_RTR, TX_ID}, {3'b001, 29'h0077});
        wait_tx(1'b0);
        cfg(6'd9, 32'h0803, 29'h0055, 29'h0, 64'h0);
        cfg(6'd10, 32'h0804, 29'h0066, 29'h0, 64'hab);
        i_eng.rx(29'h0055, 1'b0, 1'b1, 64'h0);
        rc(`OFF_FRESH_MAP, 32'h100);
        i_eng.rx(29'h0066, 1'b0, 1'b1, 64'h0);
        wait_tx(1'b1);
        chk({2'b0, TX_RTR, TX_ID}, 32'h66);
        chk(TX_DATA[31:0], 32'hab);
        wait_tx(1'b0);
        // reconfigure then free an object
        cfg(6'd3, 32'h0462, 29'h0abc, 29'h07ff, 64'h0);
        cmd(`CMD_READ, 6'd3);
        rc(`OFF_STG_CFG, 32'h0462);
        rc(`OFF_STG_ID, 32'habc);
        cmd(`CMD_CLEAR, 6'd3);
        rc(`OFF_VALID_MAP, 32'h313);
        test_done;
    end
endmodule // tb
